/* verilog/selfid_iso_pkg.sv */
// constants for the self-id status and upper isochronous channel mask bank
// shared by the register bank and its channel filter
package selfid_iso_pkg;

  localparam int unsigned addr_w    = 8;
  localparam int unsigned data_w    = 32;
  localparam int unsigned gen_w     = 8;
  localparam int unsigned size_w    = 9;
  localparam int unsigned chan_w    = 6;
  localparam int unsigned irq_w     = 4;

  // register offsets (byte addresses)
  localparam logic [7:0] selfid_count_addr   = 8'h68;
  localparam logic [7:0] upper_mask_set_addr = 8'h70;
  localparam logic [7:0] upper_mask_clr_addr = 8'h74;
  localparam logic [7:0] link_control_addr   = 8'hA0;
  localparam logic [7:0] buffer_base_addr    = 8'hA4;
  localparam logic [7:0] irq_status_addr     = 8'hA8;
  localparam logic [7:0] irq_clear_addr      = 8'hAC;
  localparam logic [7:0] irq_enable_addr     = 8'hB0;

  // self-id status word layout
  localparam int unsigned err_bit   = 31;
  localparam int unsigned gen_lsb   = 16;
  localparam int unsigned size_lsb  = 2;

  // link control layout
  localparam int unsigned link_enable_bit = 0;

  // buffer base is 2k-byte aligned: bits below this read zero
  localparam int unsigned base_lsb  = 11;
  localparam int unsigned base_w    = 21;
  localparam int unsigned quad_lsb  = 2;

  // upper mask covers channels 32..63
  localparam logic [5:0] upper_chan_first = 6'h20;
  localparam int unsigned upper_sel_bit   = 5;

  // interrupt status bit positions
  localparam int unsigned irq_bus_reset = 0;
  localparam int unsigned irq_rx_done   = 1;
  localparam int unsigned irq_rx_error  = 2;
  localparam int unsigned irq_discard   = 3;

  // reset values and the size count limit
  localparam logic [31:0] zero_word       = 32'h0000_0000;
  localparam logic [31:0] mask_reset      = 32'h0000_0000;
  localparam logic [7:0]  gen_reset       = 8'h00;
  localparam logic [8:0]  size_reset      = 9'h000;
  localparam logic [8:0]  size_max        = 9'h1FF;

  typedef enum logic [0:0] {
    rx_idle      = 1'b0,
    rx_receiving = 1'b1
  } rx_state_e;

endpackage

/* verilog/upper_channel_filter.sv */
// channel filter for the upper block of isochronous channels
// expects a registered mask and a channel number valid beside iso_valid
`timescale 1ns/1ps

module upper_channel_filter #(
  parameter int unsigned lanes = 32
) (
  // mask and channel
  input  wire logic [lanes-1:0]                     iso_rx_upper_channel_enable,
  input  wire logic [selfid_iso_pkg::chan_w-1:0]    channel,
  // result
  output logic                                      upper_hit,
  output logic                                      in_upper_block
);
  import selfid_iso_pkg::*;

  logic [lanes-1:0] lane_hit;

  // lane k matches channel 32+k only when its enable bit is set
  genvar k;
  generate
    for (k = 0; k < lanes; k++) begin : g_lane
      assign lane_hit[k] = iso_rx_upper_channel_enable[k] &&
                           (channel == (upper_chan_first + chan_w'(k)));
    end
  endgenerate

  assign in_upper_block = channel[upper_sel_bit];
  assign upper_hit      = |lane_hit;

endmodule

/* verilog/selfid_status_iso_channel_filter.sv */
// self-id status word, upper isochronous channel mask and their receive-side logic
// assumes event pulses from the receive path are one cycle long and synchronous
`timescale 1ns/1ps

module selfid_status_iso_channel_filter (
  // clock and reset
  input  wire logic                                 clock,
  input  wire logic                                 resetn,
  // register port
  input  wire logic [selfid_iso_pkg::addr_w-1:0]    reg_addr,
  input  wire logic [selfid_iso_pkg::data_w-1:0]    reg_wdata,
  input  wire logic                                 reg_write,
  input  wire logic                                 reg_read,
  output logic [selfid_iso_pkg::data_w-1:0]         reg_rdata,
  // self-id reception events
  input  wire logic                                 bus_reset_seen,
  input  wire logic                                 selfid_start,
  input  wire logic                                 selfid_quadlet_written,
  input  wire logic                                 selfid_end,
  input  wire logic                                 selfid_fault,
  input  wire logic                                 host_write_fail,
  // buffer side
  output logic [selfid_iso_pkg::data_w-1:0]         selfid_write_addr,
  output logic                                      selfid_buffer_valid,
  // isochronous filter
  input  wire logic                                 iso_valid,
  input  wire logic [selfid_iso_pkg::chan_w-1:0]    iso_channel,
  input  wire logic                                 iso_lower_hit,
  output logic                                      iso_accept,
  output logic                                      iso_discard,
  // link control and interrupt
  output logic                                      link_operation_enable,
  output logic                                      irq
);
  import selfid_iso_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // register decode

  logic wr_mask_set;
  logic wr_mask_clr;
  logic wr_link;
  logic wr_base;
  logic wr_irq_clr;
  logic wr_irq_en;

  assign wr_mask_set = reg_write && (reg_addr == upper_mask_set_addr);
  assign wr_mask_clr = reg_write && (reg_addr == upper_mask_clr_addr);
  assign wr_link     = reg_write && (reg_addr == link_control_addr);
  assign wr_base     = reg_write && (reg_addr == buffer_base_addr);
  assign wr_irq_clr  = reg_write && (reg_addr == irq_clear_addr);
  assign wr_irq_en   = reg_write && (reg_addr == irq_enable_addr);

  ////////////////////////////////////////////////////////////////////////////////
  // control registers

  logic [data_w-1:0] mask_reg;
  logic [data_w-1:0] mask_next;
  logic              link_en_reg;
  logic              link_en_next;
  logic [base_w-1:0] base_reg;
  logic [base_w-1:0] base_next;

  always_comb begin
    mask_next    = mask_reg;
    link_en_next = link_en_reg;
    base_next    = base_reg;
    if (wr_mask_set) begin
      mask_next = mask_reg | reg_wdata;
    end
    if (wr_mask_clr) begin
      mask_next = mask_reg & ~reg_wdata;
    end
    if (wr_link) begin
      link_en_next = reg_wdata[link_enable_bit];
    end
    if (wr_base) begin
      base_next = reg_wdata[data_w-1:base_lsb];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mask_reg    <= mask_reset;
      link_en_reg <= 1'b0;
      base_reg    <= '0;
    end else begin
      mask_reg    <= mask_next;
      link_en_reg <= link_en_next;
      base_reg    <= base_next;
    end
  end

  assign link_operation_enable = link_en_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // self-id reception tracking

  // with the link off every receive event is dropped at the door
  logic ev_reset;
  logic ev_start;
  logic ev_quad;
  logic ev_end;
  logic ev_err;

  assign ev_reset = bus_reset_seen && link_en_reg;
  assign ev_start = selfid_start && link_en_reg;
  assign ev_quad  = selfid_quadlet_written && link_en_reg;
  assign ev_end   = selfid_end && link_en_reg;
  assign ev_err   = (selfid_fault || host_write_fail) && link_en_reg;

  rx_state_e          rx_state_reg;
  rx_state_e          rx_state_next;
  logic               err_flag_reg;
  logic               err_flag_next;
  logic               err_seen_reg;
  logic               err_seen_next;
  logic [gen_w-1:0]   gen_reg;
  logic [gen_w-1:0]   gen_next;
  logic [size_w-1:0]  size_reg;
  logic [size_w-1:0]  size_next;
  logic               rx_done_pulse;
  logic               rx_err_pulse;

  always_comb begin
    rx_state_next = rx_state_reg;
    err_flag_next = err_flag_reg;
    err_seen_next = err_seen_reg;
    size_next     = size_reg;
    gen_next      = gen_reg;
    rx_done_pulse = 1'b0;
    rx_err_pulse  = 1'b0;
    if (ev_reset) begin
      gen_next = gen_reg + 8'h01;
    end
    unique case (rx_state_reg)
      rx_idle: begin
        if (ev_start) begin
          rx_state_next = rx_receiving;
          size_next     = size_reset;
          err_seen_next = ev_err;
        end
      end
      rx_receiving: begin
        if (ev_start) begin
          // restart: a new reception discards the partial count
          size_next     = size_reset;
          err_seen_next = ev_err;
        end else begin
          if (ev_quad && (size_reg != size_max)) begin
            size_next = size_reg + 9'h001;
          end
          if (ev_err) begin
            err_seen_next = 1'b1;
          end
          if (ev_end) begin
            rx_state_next = rx_idle;
            rx_done_pulse = 1'b1;
            if (err_seen_reg || ev_err) begin
              err_flag_next = 1'b1;
              rx_err_pulse  = 1'b1;
            end else begin
              err_flag_next = 1'b0;
            end
          end
        end
      end
    endcase
    // an error flags the status as soon as it is seen, not only at the end
    if (ev_err && (rx_state_reg == rx_receiving || ev_start)) begin
      err_flag_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_state_reg <= rx_idle;
      err_flag_reg <= 1'b0;
      err_seen_reg <= 1'b0;
      gen_reg      <= gen_reset;
      size_reg     <= size_reset;
    end else begin
      rx_state_reg <= rx_state_next;
      err_flag_reg <= err_flag_next;
      err_seen_reg <= err_seen_next;
      gen_reg      <= gen_next;
      size_reg     <= size_next;
    end
  end

  // next quadlet lands at base plus four times the count
  logic [data_w-1:0] write_addr_reg;
  logic [data_w-1:0] write_addr_next;

  always_comb begin
    write_addr_next = {base_reg, {base_lsb{1'b0}}} |
                      data_w'({size_next, {quad_lsb{1'b0}}});
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      write_addr_reg <= zero_word;
    end else begin
      write_addr_reg <= write_addr_next;
    end
  end

  assign selfid_write_addr = write_addr_reg;

  // buffer trusted whenever idle with the error flag clear; reset loads it low, and it rises on the first clock after reset, before any reception
  logic buf_valid_reg;
  logic buf_valid_next;

  always_comb begin
    buf_valid_next = (rx_state_next == rx_idle) && !err_flag_next;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      buf_valid_reg <= 1'b0;
    end else begin
      buf_valid_reg <= buf_valid_next;
    end
  end

  assign selfid_buffer_valid = buf_valid_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // isochronous channel filter

  logic upper_hit;
  logic in_upper;

  upper_channel_filter #(
    .lanes (data_w)
  ) u_filter (
    .iso_rx_upper_channel_enable (mask_reg),
    .channel                     (iso_channel),
    .upper_hit                   (upper_hit),
    .in_upper_block              (in_upper)
  );

  logic chan_ok;

  // lower channels defer to the lower mask held elsewhere
  assign chan_ok     = in_upper ? upper_hit : iso_lower_hit;
  assign iso_accept  = iso_valid && link_en_reg && chan_ok;
  assign iso_discard = iso_valid && !(link_en_reg && chan_ok);

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status

  logic [irq_w-1:0] irq_stat_reg;
  logic [irq_w-1:0] irq_stat_next;
  logic [irq_w-1:0] irq_en_reg;
  logic [irq_w-1:0] irq_en_next;
  logic [irq_w-1:0] irq_events;

  always_comb begin
    irq_events                = '0;
    irq_events[irq_bus_reset] = ev_reset;
    irq_events[irq_rx_done]   = rx_done_pulse;
    irq_events[irq_rx_error]  = rx_err_pulse;
    irq_events[irq_discard]   = iso_discard;
  end

  always_comb begin
    irq_stat_next = irq_stat_reg;
    irq_en_next   = irq_en_reg;
    if (wr_irq_clr) begin
      irq_stat_next = irq_stat_reg & ~reg_wdata[irq_w-1:0];
    end
    // a new event in the clearing cycle survives the clear
    irq_stat_next = irq_stat_next | irq_events;
    if (wr_irq_en) begin
      irq_en_next = reg_wdata[irq_w-1:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_en_reg   <= irq_en_next;
    end
  end

  logic irq_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_next & irq_en_next);
    end
  end

  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // read data

  logic [data_w-1:0] status_word;
  logic [data_w-1:0] rdata_reg;
  logic [data_w-1:0] rdata_next;

  // unused ranges stay zero by construction
  always_comb begin
    status_word                          = zero_word;
    status_word[err_bit]                 = err_flag_reg;
    status_word[gen_lsb +: gen_w]        = gen_reg;
    status_word[size_lsb +: size_w]      = size_reg;
  end

  always_comb begin
    rdata_next = zero_word;
    if (reg_read) begin
      unique case (reg_addr)
        selfid_count_addr:   rdata_next = status_word;
        upper_mask_set_addr: rdata_next = mask_reg;
        upper_mask_clr_addr: rdata_next = mask_reg;
        link_control_addr:   rdata_next = data_w'(link_en_reg);
        buffer_base_addr:    rdata_next = {base_reg, {base_lsb{1'b0}}};
        irq_status_addr:     rdata_next = data_w'(irq_stat_reg);
        irq_enable_addr:     rdata_next = data_w'(irq_en_reg);
        default:             rdata_next = zero_word;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= zero_word;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

/* bench/selfid_status_iso_channel_filter_checker.sv */
// checker for the self-id status word and upper channel mask bank
// sees only the block ports; bound onto every instance of the block
`timescale 1ns/1ps

module selfid_status_iso_channel_filter_checker
  import selfid_iso_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  // reception events
  input wire logic        bus_reset_seen,
  input wire logic        selfid_start,
  input wire logic        selfid_quadlet_written,
  input wire logic        selfid_end,
  input wire logic        selfid_fault,
  input wire logic        host_write_fail,
  input wire logic [31:0] selfid_write_addr,
  input wire logic        selfid_buffer_valid,
  // filter and control
  input wire logic        iso_valid,
  input wire logic [5:0]  iso_channel,
  input wire logic        iso_lower_hit,
  input wire logic        iso_accept,
  input wire logic        iso_discard,
  input wire logic        link_operation_enable,
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // shadow state rebuilt from the port traffic
  logic [31:0] mask_reg, mask_next;
  logic [7:0]  gen_reg, gen_next;
  logic        rx_reg, rx_next, err_reg, err_next, ev;

  always_comb begin
    ev = link_operation_enable;
    mask_next = mask_reg;
    gen_next = gen_reg;
    rx_next = rx_reg;
    err_next = err_reg;
    if (reg_write && reg_addr == upper_mask_set_addr) mask_next = mask_reg | reg_wdata;
    if (reg_write && reg_addr == upper_mask_clr_addr) mask_next = mask_reg & ~reg_wdata;
    if (ev && bus_reset_seen) gen_next = gen_reg + 8'h01;
    if (ev && rx_reg && (selfid_fault || host_write_fail)) err_next = 1'b1;
    if (ev && selfid_end) rx_next = 1'b0;
    if (ev && selfid_start) begin
      rx_next = 1'b1;
      err_next = selfid_fault || host_write_fail;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mask_reg <= 32'h0000_0000;
      gen_reg <= 8'h00;
      rx_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      gen_reg <= gen_next;
      rx_reg <= rx_next;
      err_reg <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  status_reserved_a: assert property (reg_read && reg_addr == selfid_count_addr
    |=> reg_rdata[30:24] == 7'h00 && reg_rdata[15:11] == 5'h00 && reg_rdata[1:0] == 2'h0)
    else $error("status word reserved bits not zero");
  gen_count_a: assert property (reg_read && reg_addr == selfid_count_addr
    |=> reg_rdata[23:16] == $past(gen_reg)) else $error("generation count wrong");
  mask_read_a: assert property (reg_read && (reg_addr == upper_mask_set_addr
    || reg_addr == upper_mask_clr_addr) |=> reg_rdata == $past(mask_reg))
    else $error("mask readback wrong");
  upper_accept_a: assert property (iso_valid && ev && iso_channel[5]
    |-> iso_accept == mask_reg[iso_channel[4:0]]) else $error("upper channel accept wrong");
  lower_pass_a: assert property (iso_valid && ev && !iso_channel[5]
    |-> iso_accept == iso_lower_hit) else $error("lower channel accept wrong");
  link_off_a: assert property (iso_valid && !ev |-> iso_discard && !iso_accept)
    else $error("packet taken with link disabled");
  discard_pair_a: assert property (iso_discard == (iso_valid && !iso_accept)
    && !(iso_accept && !iso_valid)) else $error("accept and discard inconsistent");
  start_clear_a: assert property (selfid_start && ev
    |=> selfid_write_addr[10:0] == 11'h000 && !selfid_buffer_valid)
    else $error("size not cleared at reception start");
  quad_step_a: assert property (selfid_quadlet_written && ev && rx_reg && !selfid_start
    && !selfid_end |=> selfid_write_addr == $past(selfid_write_addr) + 32'h0000_0004)
    else $error("quadlet count did not step");
  end_flag_a: assert property (selfid_end && ev && rx_reg
    |=> selfid_buffer_valid == !($past(err_reg) || $past(selfid_fault) || $past(host_write_fail)))
    else $error("error flag wrong after reception");

  cover property (irq);
  cover property (iso_accept && iso_channel[5]);
  cover property (selfid_end && rx_reg && err_reg);
endmodule

bind selfid_status_iso_channel_filter selfid_status_iso_channel_filter_checker chk (
  .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .bus_reset_seen(bus_reset_seen), .selfid_start(selfid_start),
  .selfid_quadlet_written(selfid_quadlet_written), .selfid_end(selfid_end),
  .selfid_fault(selfid_fault), .host_write_fail(host_write_fail),
  .selfid_write_addr(selfid_write_addr), .selfid_buffer_valid(selfid_buffer_valid),
  .iso_valid(iso_valid), .iso_channel(iso_channel), .iso_lower_hit(iso_lower_hit),
  .iso_accept(iso_accept), .iso_discard(iso_discard),
  .link_operation_enable(link_operation_enable), .irq(irq));

/* bench/selfid_rx_path_model.sv */
// behavioural receive path: bus reset, then one self-id reception
// one command at a time; the bench waits for busy to fall
`timescale 1ns/1ps

module selfid_rx_path_model (
  // clock and command
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic [4:0] nq,
  input  wire logic [1:0] err_kind,
  input  wire logic       slow,
  // event pulses
  output logic            bus_reset_seen,
  output logic            selfid_start,
  output logic            selfid_quadlet_written,
  output logic            selfid_end,
  output logic            selfid_fault,
  output logic            host_write_fail,
  output logic            busy
);
  logic [4:0] count_reg;
  logic [1:0] kind_reg;
  logic       slow_reg;

  initial begin
    {bus_reset_seen, selfid_start, selfid_quadlet_written, selfid_end} = 4'h0;
    {selfid_fault, host_write_fail, busy} = 3'h0;
  end

  always @(posedge clock) begin
    if (go && !busy) begin
      count_reg = nq;
      kind_reg = err_kind;
      slow_reg = slow;
      busy <= 1'b1;
      bus_reset_seen <= 1'b1;
      @(posedge clock);
      bus_reset_seen <= 1'b0;
      selfid_start <= 1'b1;
      @(posedge clock);
      selfid_start <= 1'b0;
      // first pulse is the header quadlet; the fault lands on the last one
      while (count_reg != 5'h00) begin
        selfid_quadlet_written <= 1'b1;
        selfid_fault <= (kind_reg == 2'h1) && (count_reg == 5'h01);
        host_write_fail <= (kind_reg == 2'h2) && (count_reg == 5'h01);
        count_reg = count_reg - 5'h01;
        @(posedge clock);
        {selfid_quadlet_written, selfid_fault, host_write_fail} <= 3'h0;
        @(posedge clock);
        if (slow_reg) repeat (2) @(posedge clock);
      end
      selfid_end <= 1'b1;
      @(posedge clock);
      selfid_end <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule

/* bench/selfid_status_iso_channel_filter_test.sv */
// self-checking bench for the self-id status and upper mask bank
// drives the register port and filter; the rx model makes the events
`timescale 1ns/1ps

module selfid_status_iso_channel_filter_test;
  import selfid_iso_pkg::*;
  logic        clock, resetn, reg_write, reg_read, go, slow, busy, rd_d, link_on, irq_exp;
  logic        iso_valid, iso_lower_hit, iso_accept, iso_discard, bus_reset_seen;
  logic        selfid_start, selfid_quadlet_written, selfid_end, selfid_fault;
  logic        host_write_fail, selfid_buffer_valid, link_operation_enable, irq;
  logic [7:0]  reg_addr, gen_exp;
  logic [31:0] reg_wdata, reg_rdata, selfid_write_addr, seed, mask_exp, st_exp;
  logic [5:0]  iso_channel;
  logic [4:0]  nq;
  logic [1:0]  err_kind;
  logic [32:0] rq[$];
  logic [1:0]  iq[$];
  int          num_errors, compares;

  selfid_status_iso_channel_filter dut (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .bus_reset_seen(bus_reset_seen), .selfid_start(selfid_start),
    .selfid_quadlet_written(selfid_quadlet_written), .selfid_end(selfid_end),
    .selfid_fault(selfid_fault), .host_write_fail(host_write_fail),
    .selfid_write_addr(selfid_write_addr), .selfid_buffer_valid(selfid_buffer_valid),
    .iso_valid(iso_valid), .iso_channel(iso_channel), .iso_lower_hit(iso_lower_hit),
    .iso_accept(iso_accept), .iso_discard(iso_discard),
    .link_operation_enable(link_operation_enable), .irq(irq));

  selfid_rx_path_model rxm (
    .clock(clock), .go(go), .nq(nq), .err_kind(err_kind), .slow(slow),
    .bus_reset_seen(bus_reset_seen), .selfid_start(selfid_start),
    .selfid_quadlet_written(selfid_quadlet_written), .selfid_end(selfid_end),
    .selfid_fault(selfid_fault), .host_write_fail(host_write_fail), .busy(busy));

  always #2 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_of_test;
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read data and the irq level are compared in the cycle after each read
  always @(posedge clock) rd_d <= reg_read;
  always @(negedge clock) begin
    if (rd_d) chk({irq, reg_rdata}, rq.pop_front());
    if (iso_valid) chk({31'h0, iso_accept, iso_discard}, {31'h0, iq.pop_front()});
  end

  ////////////////////////////////////////////////////////////////////////////
  // each access leaves an idle cycle so no strobe is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back({irq_exp, e});
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
  endtask

  task automatic iso(input logic [5:0] ch, input logic lh, input logic [1:0] e);
    iq.push_back(e);
    iso_channel <= ch;
    iso_lower_hit <= lh;
    iso_valid <= 1'b1;
    @(posedge clock);
    iso_valid <= 1'b0;
    @(posedge clock);
  endtask

  task automatic sweep;
    logic a;
    for (int c = 0; c < 64; c++) begin
      seed = lfsr(seed);
      a = link_on && (c[5] ? mask_exp[c[4:0]] : seed[0]);
      iso(c[5:0], seed[0], {a, !a});
    end
  endtask

  task automatic rx(input logic [1:0] ek);
    logic [4:0] n;
    seed = lfsr(seed);
    n = {1'b0, seed[3:0]} + 5'h01;
    nq <= n;
    err_kind <= ek;
    slow <= seed[4];
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (150) begin
      @(posedge clock);
      if (!busy) break;
    end
    if (busy) begin
      num_errors++;
      $display("MISMATCH at %0t: receive model never finished", $time);
      end_of_test;
    end
    if (link_on) begin
      gen_exp++;
      st_exp = {ek != 2'h0, 7'h00, gen_exp, 5'h00, 4'h0, n, 2'h0};
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clock, resetn, reg_write, reg_read, go, slow, iso_valid, iso_lower_hit} = 8'h00;
    {reg_addr, reg_wdata, iso_channel, nq, err_kind} = 53'h0;
    {link_on, irq_exp, gen_exp, mask_exp, st_exp} = 74'h0;
    seed = 32'hcf84_bcd2;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(selfid_count_addr, zero_word);
    rd(upper_mask_set_addr, mask_reset);
    rd(8'h10, zero_word);
    wr(selfid_count_addr, 32'hFFFF_FFFF);
    rd(selfid_count_addr, zero_word);
    wr(upper_mask_set_addr, 32'hFFFF_FFFF);
    mask_exp = 32'hFFFF_FFFF;
    sweep;
    rx(2'h0);
    rd(selfid_count_addr, zero_word);
    wr(irq_clear_addr, 32'h0000_000F);
    wr(link_control_addr, 32'h0000_0001);
    wr(irq_enable_addr, 32'h0000_000F);
    link_on = 1'b1;
    // status was just cleared, so the line stays low until the first reception
    rd(link_control_addr, 32'h0000_0001);
    irq_exp = 1'b1;
    // clean, internal fault, failed host write, then clean again
    for (int j = 0; j < 4; j++) begin
      rx(j < 3 ? j[1:0] : 2'h0);
      rd(selfid_count_addr, st_exp);
    end
    rd(irq_status_addr, 32'h0000_0007);
    wr(irq_enable_addr, 32'h0000_0000);
    irq_exp = 1'b0;
    rd(irq_status_addr, 32'h0000_0007);
    wr(irq_enable_addr, 32'h0000_000F);
    wr(irq_clear_addr, 32'h0000_000F);
    rd(irq_status_addr, zero_word);
    seed = lfsr(seed);
    wr(upper_mask_clr_addr, seed);
    mask_exp = mask_exp & ~seed;
    seed = lfsr(seed);
    wr(upper_mask_set_addr, seed & 32'h0000_FFFF);
    mask_exp = mask_exp | (seed & 32'h0000_FFFF);
    rd(upper_mask_set_addr, mask_exp);
    rd(upper_mask_clr_addr, mask_exp);
    seed = lfsr(seed);
    wr(buffer_base_addr, seed);
    rd(buffer_base_addr, {seed[31:11], 11'h000});
    sweep;
    irq_exp = 1'b1;
    rd(irq_status_addr, 32'h0000_0008);
    wr(link_control_addr, zero_word);
    link_on = 1'b0;
    sweep;
    rx(2'h1);
    rd(selfid_count_addr, st_exp);
    wr(link_control_addr, 32'h0000_0001);
    link_on = 1'b1;
    while (gen_exp != 8'h00) rx(2'h0);
    rd(selfid_count_addr, st_exp);
    end_of_test;
  end
endmodule
